// ---- dmtl_loader.v ----
// Purpose: Tape loader for the writable diagnostic store, plus kernel priority
// Assumes: Read bus lines asynchronous to i_mclk; other inputs on i_mclk
// Notes: Words queue in a FIFO; i_store_hold stalls store writes
`timescale 1ns/1ps
`include "dmtl_regs.vh"
module dmtl_loader #(
    parameter ENV_HOLD = `DMTL_ENV_HOLD_CYC,
    parameter DLY_UNIT = `DMTL_DLY_UNIT_CYC,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire i_mclk,
    input wire i_rst,
    input wire [8:0] i_read_bus,
    input wire i_load_en,
    input wire i_load_addr_set,
    input wire [15:0] i_load_addr,
    input wire i_store_hold,
    input wire [15:0] i_cs_addr,
    input wire [15:0] i_rom_data,
    input wire i_maint_mode,
    input wire i_diag_enable,
    input wire i_cpu_cmd,
    input wire [15:0] i_delay_setting,
    input wire i_kernel_req,
    input wire i_kernel_done,
    input wire i_kernel_fail,
    input wire [7:0] i_fail_code,
    input wire i_error_clear,
    output wire [8:0] o_track_live,
    output wire o_bypass_detect,
    output wire o_marker_seen,
    output reg [15:0] o_word,
    output reg o_store_wr,
    output reg [6:0] o_store_wr_addr,
    output wire [15:0] o_control_store_address_register,
    output reg [7:0] o_word_count,
    output reg o_overrun,
    output reg [15:0] o_control_store_data_register,
    output wire o_kernel_run,
    output reg o_kernel_go,
    output reg o_kernel_yield,
    output wire o_channel_priority,
    output reg [7:0] o_error_code,
    output wire o_error
);
    reg [15:0] word_assembly_register;
    reg [3:0] steer_reg;
    reg time_live_reg;
    reg data_seen_reg;
    reg mark_seen_reg;
    reg [15:0] addr_reg;
    reg [15:0] store [0:`DMTL_STORE_WORDS-1];
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] dly_reg;
    reg [15:0] div_reg;
    reg tick_reg;
    wire [8:0] live;
    wire data_vote;
    wire time_vote;
    wire mark_now;
    wire cell_end;
    wire bit_val;
    wire word_done;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire drain;
    wire in_store;

    // Two-of-three vote
    function maj3;
        input a;
        input b;
        input c;
        begin
            maj3 = (a & b) | (a & c) | (b & c);
        end
    endfunction

    // [RULE11] envelope path only
    dmtl_env #(
        .N(9),
        .HOLD(ENV_HOLD),
        .CW(16)
    ) u_env (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_line(i_read_bus),
        .o_live(live)
    );

    assign o_track_live = live;
    assign o_bypass_detect = i_load_en;

    // [RULE1] track group voting
    // [RULE3] two of three
    assign data_vote = maj3(live[`DMTL_TRK_DATA_A], live[`DMTL_TRK_DATA_B],
                            live[`DMTL_TRK_DATA_C]);
    assign time_vote = maj3(live[`DMTL_TRK_TIME_A], live[`DMTL_TRK_TIME_B],
                            live[`DMTL_TRK_TIME_C]);
    // [RULE2] marker on tracks 0 and 5
    assign mark_now = live[`DMTL_TRK_MARK_A] & live[`DMTL_TRK_MARK_B];
    assign o_marker_seen = mark_seen_reg;

    // [RULE5] one burst is one cell
    // [RULE6] end of timing activity
    assign cell_end = i_load_en & time_live_reg & !time_vote;
    // [RULE4] live data in cell is a one
    assign bit_val = data_seen_reg | data_vote;
    // Markers block completion, so a cut word never reaches the FIFO
    assign word_done = cell_end && !(mark_seen_reg | mark_now) && (steer_reg == `DMTL_PTR_LAST);

    // Cell tracking: data and marker seen while timing live
    always @(posedge i_mclk) begin
        if (i_rst) begin
            time_live_reg <= 1'b0;
            data_seen_reg <= 1'b0;
            mark_seen_reg <= 1'b0;
        end else begin
            time_live_reg <= time_vote;
            if (!time_vote) begin
                data_seen_reg <= 1'b0;
                mark_seen_reg <= 1'b0;
            end else begin
                data_seen_reg <= data_seen_reg | data_vote;
                mark_seen_reg <= mark_seen_reg | mark_now;
            end
        end
    end

    // Word assembly and steering pointer
    always @(posedge i_mclk) begin
        if (i_rst) begin
            word_assembly_register <= 16'h0000;
            steer_reg <= 4'h0;
        end else if (!i_load_en) begin
            steer_reg <= 4'h0;
        end else if (mark_now) begin
            // [RULE20] marker clears pointer even without timing
            steer_reg <= 4'h0;
        end else if (cell_end) begin
            if (mark_seen_reg | mark_now) begin
                // [RULE20] block start clears pointer
                steer_reg <= 4'h0;
            end else begin
                // [RULE7] store bit then step
                word_assembly_register[steer_reg] <= bit_val;
                steer_reg <= steer_reg + 4'h1;
            end
        end
    end

    // Completed word, with the last bit merged in
    always @(posedge i_mclk) begin
        if (i_rst)
            o_word <= 16'h0000;
        else if (word_done)
            o_word <= (word_assembly_register & ~(16'h0001 << steer_reg))
                      | ({15'h0000, bit_val} << steer_reg);
    end

    // Overrun when a word finds the FIFO full
    always @(posedge i_mclk) begin
        if (i_rst)
            o_overrun <= 1'b0;
        else if (word_done && !fifo_in_ready)
            o_overrun <= 1'b1;
        else if (i_load_addr_set)
            o_overrun <= 1'b0;
    end

    // Word pushed the cycle after it completes
    reg push_reg;
    always @(posedge i_mclk) begin
        if (i_rst)
            push_reg <= 1'b0;
        else
            push_reg <= word_done && fifo_in_ready;
    end

    dmtl_fifo #(
        .W(`DMTL_WORD_BITS),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_in_valid(push_reg),
        .o_in_ready(fifo_in_ready),
        .i_in_data(o_word),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(drain),
        .o_out_data(fifo_out_data)
    );

    // Drain stalls while the sequencer holds the store
    assign drain = fifo_out_valid && !i_store_hold && !o_store_wr;

    // [RULE21] one-cycle write strobe
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_store_wr <= 1'b0;
            o_store_wr_addr <= 7'h00;
        end else begin
            o_store_wr <= drain;
            if (drain)
                o_store_wr_addr <= addr_reg[6:0];
        end
    end

    // [RULE8] write at address bits 9-15
    // [RULE10] 128-word store
    always @(posedge i_mclk) begin
        if (drain)
            store[addr_reg[6:0]] <= fifo_out_data;
    end

    // [RULE9] address steps per word
    always @(posedge i_mclk) begin
        if (i_rst)
            addr_reg <= `DMTL_ADDR_RST;
        else if (i_load_addr_set)
            addr_reg <= i_load_addr;
        else if (drain)
            addr_reg <= addr_reg + 16'h0001;
    end
    assign o_control_store_address_register = addr_reg;

    // Word counter per block
    always @(posedge i_mclk) begin
        if (i_rst)
            o_word_count <= 8'h00;
        else if (i_load_addr_set)
            o_word_count <= 8'h00;
        else if (i_load_en && mark_now)
            // [RULE20] marker tracks alone also clear count
            o_word_count <= 8'h00;
        else if (cell_end && (mark_seen_reg | mark_now))
            // [RULE20] block start clears count
            o_word_count <= 8'h00;
        else if (word_done)
            o_word_count <= o_word_count + 8'h01;
    end

    // [RULE19] store overrides fixed store
    assign in_store = (i_cs_addr >= `DMTL_STORE_BASE) && i_maint_mode && i_diag_enable;
    always @(posedge i_mclk) begin
        if (i_rst)
            o_control_store_data_register <= 16'h0000;
        else if (in_store)
            o_control_store_data_register <= store[i_cs_addr[6:0]];
        else
            o_control_store_data_register <= i_rom_data;
    end

    // Delay unit tick divider
    always @(posedge i_mclk) begin
        if (i_rst) begin
            div_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (div_reg == DLY_UNIT[15:0] - 16'h0001) begin
            div_reg <= 16'h0000;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // [RULE13] reload delay on each command
    // [RULE16] operator sets the length
    always @(posedge i_mclk) begin
        if (i_rst)
            dly_reg <= 16'h0000;
        else if (i_cpu_cmd)
            dly_reg <= i_delay_setting;
        else if (tick_reg && dly_reg != 16'h0000)
            dly_reg <= dly_reg - 16'h0001;
    end

    // Kernel priority state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `DMTL_ST_WAIT: begin
                // [RULE14] delay expired
                if (!i_cpu_cmd && dly_reg == 16'h0000)
                    state_next = `DMTL_ST_READY;
            end
            `DMTL_ST_READY: begin
                if (i_cpu_cmd)
                    state_next = `DMTL_ST_WAIT;
                else if (i_kernel_req)
                    state_next = `DMTL_ST_RUN;
            end
            `DMTL_ST_RUN: begin
                // [RULE15] channel takes back control
                if (i_cpu_cmd)
                    state_next = `DMTL_ST_WAIT;
                else if (i_kernel_fail)
                    state_next = `DMTL_ST_HALT;
                else if (i_kernel_done)
                    state_next = `DMTL_ST_READY;
            end
            `DMTL_ST_HALT: begin
                if (i_error_clear)
                    state_next = `DMTL_ST_WAIT;
            end
            default: begin
                state_next = `DMTL_ST_WAIT;
            end
        endcase
    end

    // State register and pulses
    always @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= `DMTL_ST_WAIT;
            o_kernel_go <= 1'b0;
            o_kernel_yield <= 1'b0;
        end else begin
            state_reg <= state_next;
            o_kernel_go <= (state_reg == `DMTL_ST_READY) && (state_next == `DMTL_ST_RUN);
            o_kernel_yield <= (state_reg == `DMTL_ST_RUN) && i_cpu_cmd;
        end
    end

    // [RULE17] latch error code on failure
    always @(posedge i_mclk) begin
        if (i_rst)
            o_error_code <= 8'h00;
        else if (state_reg == `DMTL_ST_RUN && !i_cpu_cmd && i_kernel_fail)
            o_error_code <= i_fail_code;
        else if (state_reg == `DMTL_ST_HALT && i_error_clear)
            o_error_code <= 8'h00;
    end

    assign o_kernel_run = (state_reg == `DMTL_ST_RUN);
    assign o_error = (state_reg == `DMTL_ST_HALT);
    // Channel has priority except while a kernel runs; a command then preempts it
    assign o_channel_priority = !o_kernel_run;
endmodule

// ---- dmtl_regs.vh ----
// Purpose: Constants for the diagnostic microcode tape loader
// Assumes: 125 MHz controller clock, eight-track tape read bus plus parity line
// Notes: Times are in ns; cycle counts derive from the clock period
//
// Contract
// [RULE1] Tracks 1,3,4 form the data group; tracks 2,6,7 the timing group.
// [RULE2] Tracks 0 and 5 both live mark a block boundary; data then ignored.
// [RULE3] Each voter outputs the value reported by two or three detectors.
// [RULE4] Bit is 1 when data tracks live during a timing cell, else 0.
// [RULE5] Timing bursts of 20 live bytes then 20 dead; each burst one cell.
// [RULE6] Exactly one bit captured when voted timing activity ceases.
// [RULE7] Timing pulse stores the data bit, then steps the steering pointer.
// [RULE8] After 16 bits, word written at address bits 9 through 15.
// [RULE9] Address register increments after each word write.
// [RULE10] Writable diagnostic store holds 128 sixteen-bit words.
// [RULE11] Loading bypasses normal read detection; uses envelope detectors.
// [RULE12] Envelope detector active while line carries signal, else inactive.
// [RULE13] Channel commands have priority; delay after each before a kernel.
// [RULE14] After the delay with no new command, a kernel may start.
// [RULE15] Command during a kernel returns control to channel at once.
// [RULE16] Priority delay length is set by the operator.
// [RULE17] On failure kernel stops, error code shown, channel keeps running.
// [RULE18] Tape writer uses A7, DC, 84, FF, 7B byte patterns.
// [RULE19] Store output replaces fixed store at 780 hex up when enabled.
// [RULE20] Block start marker clears steering pointer and word counter.
// [RULE21] Store write strobe lasts one clock per completed word.
`ifndef DMTL_REGS_VH
`define DMTL_REGS_VH

`define DMTL_CLK_NS 8
`define DMTL_ENV_HOLD_NS 400
`define DMTL_ENV_HOLD_CYC (`DMTL_ENV_HOLD_NS / `DMTL_CLK_NS)
`define DMTL_DLY_UNIT_NS 1000
`define DMTL_DLY_UNIT_CYC (`DMTL_DLY_UNIT_NS / `DMTL_CLK_NS)

`define DMTL_TRK_MARK_A 0
`define DMTL_TRK_MARK_B 5
`define DMTL_TRK_DATA_A 1
`define DMTL_TRK_DATA_B 3
`define DMTL_TRK_DATA_C 4
`define DMTL_TRK_TIME_A 2
`define DMTL_TRK_TIME_B 6
`define DMTL_TRK_TIME_C 7

`define DMTL_WORD_BITS 16
`define DMTL_PTR_LAST 4'hf
`define DMTL_STORE_WORDS 128
`define DMTL_STORE_BASE 16'h0780
`define DMTL_ADDR_RST 16'h0780

`define DMTL_ST_WAIT 2'h0
`define DMTL_ST_READY 2'h1
`define DMTL_ST_RUN 2'h2
`define DMTL_ST_HALT 2'h3

`endif

// ---- dmtl_env.v ----
// Purpose: Envelope detectors for the tape read bus lines
// Assumes: Read lines are asynchronous; a live track toggles often
// Notes: Output stays active for a hold time after the last edge
`timescale 1ns/1ps
module dmtl_env #(
    parameter N = 9,
    parameter HOLD = 50,
    parameter CW = 8
) (
    input wire i_mclk,
    input wire i_rst,
    input wire [N-1:0] i_line,
    output wire [N-1:0] o_live
);
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : env
            reg meta_reg;
            reg sync_reg;
            reg last_reg;
            reg [CW-1:0] hold_reg;
            // Two-stage synchroniser, then edge history
            always @(posedge i_mclk) begin
                if (i_rst) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    last_reg <= 1'b0;
                end else begin
                    meta_reg <= i_line[g];
                    sync_reg <= meta_reg;
                    last_reg <= sync_reg;
                end
            end
            // [RULE12] retriggered hold counter
            always @(posedge i_mclk) begin
                if (i_rst)
                    hold_reg <= {CW{1'b0}};
                else if (sync_reg != last_reg)
                    hold_reg <= HOLD[CW-1:0];
                else if (hold_reg != {CW{1'b0}})
                    hold_reg <= hold_reg - 1'b1;
            end
            assign o_live[g] = (hold_reg != {CW{1'b0}});
        end
    endgenerate
endmodule

// ---- dmtl_fifo.v ----
// Purpose: Word FIFO between word assembly and store writes
// Assumes: Single clock, DEPTH a power of two
// Notes: Valid/ready on both sides; full and empty are exact
`timescale 1ns/1ps
module dmtl_fifo #(
    parameter W = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_mclk,
    input wire i_rst,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_reg;
    reg [AW:0] rd_reg;
    wire empty;
    wire full;
    wire push;
    wire pop;

    // Extra pointer bit tells full from empty
    assign empty = (wr_reg == rd_reg);
    assign full = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign push = i_in_valid && !full;
    assign pop = i_out_ready && !empty;
    assign o_out_data = mem[rd_reg[AW-1:0]];

    // Storage write
    always @(posedge i_mclk) begin
        if (push)
            mem[wr_reg[AW-1:0]] <= i_in_data;
    end

    // Pointers
    always @(posedge i_mclk) begin
        if (i_rst) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule

// ---- dmtl_monitor.sv ----
// Purpose: Port-level checks for the tape loader
// Assumes: One clock domain, synchronous active-high reset
// Notes: Attached to every loader instance by bind
`timescale 1ns/1ps
module dmtl_monitor (
    input wire i_mclk,
    input wire i_rst,
    input wire i_load_en,
    input wire i_load_addr_set,
    input wire [15:0] i_cs_addr,
    input wire [15:0] i_rom_data,
    input wire i_maint_mode,
    input wire i_diag_enable,
    input wire i_cpu_cmd,
    input wire [15:0] i_delay_setting,
    input wire i_kernel_req,
    input wire i_kernel_fail,
    input wire [7:0] i_fail_code,
    input wire o_bypass_detect,
    input wire o_store_wr,
    input wire [6:0] o_store_wr_addr,
    input wire [15:0] o_control_store_address_register,
    input wire [15:0] o_control_store_data_register,
    input wire o_kernel_run,
    input wire o_kernel_go,
    input wire o_kernel_yield,
    input wire o_channel_priority,
    input wire [7:0] o_error_code,
    input wire o_error
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wr_pulse_a: assert property (o_store_wr |=> !o_store_wr)
        else $error("store write strobe longer than one cycle");
    wr_index_a: assert property (
        o_store_wr |-> o_store_wr_addr == $past(o_control_store_address_register[6:0]))
        else $error("store written at wrong index");
    addr_step_a: assert property (o_store_wr && !$past(i_load_addr_set)
        |-> o_control_store_address_register == $past(o_control_store_address_register) + 16'h0001)
        else $error("address register did not step after a write");
    bypass_path_a: assert property (o_bypass_detect == i_load_en)
        else $error("bypass flag differs from load mode");
    fetch_rom_a: assert property (!(i_cs_addr >= 16'h0780 && i_maint_mode && i_diag_enable)
        |=> o_control_store_data_register == $past(i_rom_data))
        else $error("fixed store data not passed through");
    chan_prio_a: assert property (o_channel_priority == !o_kernel_run)
        else $error("channel priority disagrees with kernel state");
    cmd_wait_a: assert property (i_cpu_cmd && i_delay_setting != 16'h0000 |=> (!o_kernel_run) [*2])
        else $error("kernel ran right after a command");
    kernel_go_a: assert property ($rose(o_kernel_run) |-> o_kernel_go && $past(i_kernel_req))
        else $error("kernel start without request or pulse");
    kernel_yield_a: assert property (o_kernel_run && i_cpu_cmd |=> !o_kernel_run && o_kernel_yield)
        else $error("kernel kept control over a command");
    kernel_halt_a: assert property (o_kernel_run && i_kernel_fail && !i_cpu_cmd
        |=> o_error && !o_kernel_run && o_error_code == $past(i_fail_code))
        else $error("failure did not stop the kernel with its code");
endmodule
bind dmtl_loader dmtl_monitor u_mon (.*);

// ---- dmtl_tape_model.sv ----
// Purpose: Tape unit read bus playing a live/dead encoded load tape
// Assumes: One byte every 125 ns; tracks 0-7 on lines 0-7
// Notes: Parity line stays dead; a dead line holds its level
`timescale 1ns/1ps
module dmtl_tape_model #(
    parameter BYTE_NS = 125
) (
    output reg [8:0] o_read_bus
);
    integer n;
    initial o_read_bus = 9'h000;
    // zero bit toggles track, one bit leaves it dead
    task play_byte(input [7:0] pat);
        begin
            for (n = 0; n < 8; n = n + 1)
                if (!pat[7 - n]) o_read_bus[n] = ~o_read_bus[n];
            #(BYTE_NS);
        end
    endtask
    // twenty pattern bytes then twenty dead bytes
    task play_cell(input [7:0] pat);
        begin
            repeat (20) play_byte(pat);
            repeat (20) play_byte(8'hff);
        end
    endtask
endmodule

// ---- dmtl_loader_bench.sv ----
// Purpose: Self-checking bench for the tape loader
// Assumes: 125 MHz clock, short delay unit of 4 cycles
// Notes: Tape model plays cells; checks at settled times
`timescale 1ns/1ps
module dmtl_loader_bench;
    reg i_mclk = 1'b0, i_rst = 1'b1, i_load_en = 1'b0, i_load_addr_set = 1'b0, i_store_hold = 1'b0;
    reg i_maint_mode = 1'b0, i_diag_enable = 1'b0, i_cpu_cmd = 1'b0, i_kernel_req = 1'b0;
    reg i_kernel_fail = 1'b0, i_error_clear = 1'b0, i_kernel_done = 1'b0;
    reg [15:0] i_load_addr = 16'h0000, i_cs_addr = 16'h0000, i_rom_data = 16'h0000, i_delay_setting = 16'h0000;
    reg [7:0] i_fail_code = 8'h00;
    wire [8:0] i_read_bus;
    wire [15:0] o_word, o_csa, o_csd;
    wire [7:0] o_word_count, o_error_code;
    wire [6:0] o_store_wr_addr;
    wire o_store_wr, o_kernel_run, o_kernel_go, o_kernel_yield, o_channel_priority, o_error;
    wire o_marker_seen, o_overrun;
    wire [8:0] o_track_live;
    integer failures = 0, n_checks = 0, n;
    // Clock
    always #4 i_mclk = ~i_mclk;
    dmtl_tape_model u_tape (.o_read_bus(i_read_bus));
    dmtl_loader #(.DLY_UNIT(4)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_read_bus(i_read_bus),
        .i_load_en(i_load_en), .i_load_addr_set(i_load_addr_set), .i_load_addr(i_load_addr),
        .i_store_hold(i_store_hold), .i_cs_addr(i_cs_addr), .i_rom_data(i_rom_data),
        .i_maint_mode(i_maint_mode), .i_diag_enable(i_diag_enable), .i_cpu_cmd(i_cpu_cmd),
        .i_delay_setting(i_delay_setting), .i_kernel_req(i_kernel_req), .i_kernel_done(i_kernel_done),
        .i_kernel_fail(i_kernel_fail), .i_fail_code(i_fail_code), .i_error_clear(i_error_clear),
        .o_track_live(o_track_live), .o_bypass_detect(), .o_marker_seen(o_marker_seen),
        .o_word(o_word), .o_store_wr(o_store_wr),
        .o_store_wr_addr(o_store_wr_addr), .o_control_store_address_register(o_csa),
        .o_word_count(o_word_count), .o_overrun(o_overrun), .o_control_store_data_register(o_csd),
        .o_kernel_run(o_kernel_run), .o_kernel_go(o_kernel_go), .o_kernel_yield(o_kernel_yield),
        .o_channel_priority(o_channel_priority), .o_error_code(o_error_code), .o_error(o_error));
    task complete_run;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Cells LSB first, some with one track of a group failed
    task send_word(input [15:0] w);
        integer i;
        begin
            for (i = 0; i < 16; i = i + 1)
                u_tape.play_cell(w[i] ? (i == 1 ? 8'hc4 : i == 6 ? 8'h85 : 8'h84) : (i == 2 ? 8'hcc : 8'hdc));
        end
    endtask
    task wait_on(input string nm, input integer lim);
        begin
            n = 0;
            while ((nm == "go" ? o_kernel_go : o_store_wr) !== 1'b1 && n < lim) begin
                @(posedge i_mclk);
                #1;
                n = n + 1;
            end
            if (n == lim) begin
                chk(nm, 16'h0001, 16'h0000);
                complete_run;
            end
        end
    endtask
    task fetch(input [15:0] a, input [15:0] e);
        begin
            @(posedge i_mclk) i_cs_addr <= a;
            repeat (2) @(posedge i_mclk);
            #1;
            chk("fetch", e, o_csd);
        end
    endtask
    task pulse_cmd;
        begin
            @(posedge i_mclk) i_cpu_cmd <= 1'b1;
            @(posedge i_mclk) i_cpu_cmd <= 1'b0;
            #1;
        end
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        chk("addr_reset", 16'h0780, o_csa);
        chk("prio_reset", 16'h0001, {15'h0, o_channel_priority});
        // Load two words at the top of the store while writes stall
        @(posedge i_mclk) i_load_en <= 1'b1;
        i_load_addr <= 16'h07fe;
        i_load_addr_set <= 1'b1;
        i_store_hold <= 1'b1;
        @(posedge i_mclk) i_load_addr_set <= 1'b0;
        u_tape.play_cell(8'h7b);
        send_word(16'ha5c3);
        chk("word", 16'ha5c3, o_word);
        chk("count", 16'h0001, {8'h0, o_word_count});
        repeat (5) u_tape.play_cell(8'h84);
        // Marker cell with timing present: tracks seen, no bit taken
        repeat (20) u_tape.play_byte(8'h58);
        chk("marker", 16'h0001, {15'h0, o_marker_seen});
        chk("track_live", 16'h00e5, {7'h0, o_track_live});
        repeat (20) u_tape.play_byte(8'hff);
        chk("count", 16'h0000, {8'h0, o_word_count});
        send_word(16'h3c96);
        chk("word", 16'h3c96, o_word);
        chk("overrun", 16'h0000, {15'h0, o_overrun});
        @(posedge i_mclk) i_store_hold <= 1'b0;
        wait_on("wr", 50);
        chk("wr_addr", 16'h007e, {9'h0, o_store_wr_addr});
        @(posedge i_mclk);
        #1;
        wait_on("wr", 50);
        chk("wr_addr", 16'h007f, {9'h0, o_store_wr_addr});
        chk("addr", 16'h0800, o_csa);
        // Store overlay only at 780 hex up in maintenance with enable
        @(posedge i_mclk) i_maint_mode <= 1'b1;
        i_diag_enable <= 1'b1;
        i_rom_data <= 16'h1234;
        fetch(16'h077f, 16'h1234);
        fetch(16'h07fe, 16'ha5c3);
        fetch(16'h07ff, 16'h3c96);
        @(posedge i_mclk) i_diag_enable <= 1'b0;
        fetch(16'h07ff, 16'h1234);
        // Command and request together: the command wins, then the delay runs
        @(posedge i_mclk) i_delay_setting <= 16'h0003;
        i_kernel_req <= 1'b1;
        i_cpu_cmd <= 1'b1;
        @(posedge i_mclk) i_cpu_cmd <= 1'b0;
        #1;
        wait_on("go", 60);
        chk("delay_ok", 16'h0001, {15'h0, (n >= 9 && n <= 15)});
        chk("run", 16'h0001, {15'h0, o_kernel_run});
        pulse_cmd;
        chk("yield", 16'h0001, {15'h0, o_kernel_yield});
        chk("prio", 16'h0001, {15'h0, o_channel_priority});
        wait_on("go", 60);
        // Kernel finishes, then starts again while the request stands
        @(posedge i_mclk) i_kernel_done <= 1'b1;
        @(posedge i_mclk) i_kernel_done <= 1'b0;
        #1;
        chk("done_run", 16'h0000, {15'h0, o_kernel_run});
        wait_on("go", 4);
        @(posedge i_mclk) i_kernel_fail <= 1'b1;
        i_fail_code <= 8'h5a;
        @(posedge i_mclk) i_kernel_fail <= 1'b0;
        i_kernel_req <= 1'b0;
        #1;
        chk("err_code", 16'h005a, {8'h0, o_error_code});
        chk("prio", 16'h0001, {15'h0, o_channel_priority});
        @(posedge i_mclk) i_error_clear <= 1'b1;
        @(posedge i_mclk) i_error_clear <= 1'b0;
        #1;
        chk("error", 16'h0000, {15'h0, o_error});
        complete_run;
    end
endmodule
